/* src/bbc_bus_ctrl.sv */
// boot chip select and sram chip select bus controller with power-on reset
// Summary of operation
// - after reset boot select is a 16-bit port with three waits until reprogrammed.
// - byte acknowledge is inverse of counter bit one; device ends as 8-bit access.
// - device holds itself in reset and drives its open-drain reset output.
// - sram completes in two clocks, or three clocks when configured slow.
`timescale 1ns/1ps
module bbc_bus_ctrl #(
    parameter int POR_HOLD = bbc_pkg::POR_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       nrst,
    // user request
    input  wire logic                       req_valid,
    input  wire logic                       req_write,
    input  wire logic                       req_word,
    input  wire logic [bbc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [bbc_pkg::DATA_W-1:0] req_wdata,
    output logic                            req_ready,
    output logic                            resp_done,
    output logic [bbc_pkg::DATA_W-1:0]      resp_rdata,
    output logic                            resp_byte_port,
    // chip select configuration
    input  wire logic                       cfg_load,
    input  wire logic                       cfg_boot_port8,
    input  wire logic [2:0]                 cfg_boot_waits,
    input  wire logic                       cfg_sram_3clk,
    // external bus
    output logic [bbc_pkg::ADDR_W-1:0]      bus_addr,
    output logic                            bus_read,
    output logic                            bus_size_byte,
    output logic                            boot_chip_select_n,
    output logic                            sram_chip_select_n,
    input  wire logic                       byte_port_size_ack_n,
    input  wire logic [bbc_pkg::DATA_W-1:0] bus_data_in,
    output logic [bbc_pkg::DATA_W-1:0]      bus_data_out,
    output logic                            bus_data_oe,
    // system reset pin
    input  wire logic                       rst_pin_in,
    output logic                            rst_pin_out,
    output logic                            rst_pin_oe
);
    import bbc_pkg::*;

    bbc_state_e          state_ff;
    bbc_state_e          nxt_state;
    logic [2:0]          cnt_ff;
    logic                boot_ff;
    logic                wr_ff;
    logic                word_ff;
    logic                second_ff;
    logic [ADDR_W-1:0]   addr_ff;
    logic [DATA_W-1:0]   wdata_ff;
    logic [DATA_W-1:0]   dout_ff;
    logic                doe_ff;
    logic                size_byte_ff;
    logic                cs_boot_n_ff;
    logic                cs_sram_n_ff;
    logic [DATA_W-1:0]   rdata_ff;
    logic                done_ff;
    logic                ready_ff;
    logic                byte_port_ff;
    logic                port8_ff;
    logic [2:0]          waits_ff;
    logic                sram3_ff;
    logic                ack_s1_ff;
    logic                ack_s2_ff;
    logic [DATA_W-1:0]   din_s1_ff;
    logic [DATA_W-1:0]   din_s2_ff;
    logic                sys_rst_n;
    logic                half_ff;
    logic                cap1_ff;
    logic                cap2_ff;

    logic                accept;
    logic                ack_seen;
    logic [2:0]          wait_limit;
    logic                term_byte;
    logic                term_word;
    logic                term;
    logic                need_second;
    logic [7:0]          lane_byte;
    logic [7:0]          byte_in;
    logic [DATA_W-1:0]   nxt_rdata;
    logic [DATA_W-1:0]   nxt_dout;
    logic                rst_n;
    logic                end_ok;
    logic                wr_next;

    bbc_por_reset #(
        .HOLD_CYCLES (POR_HOLD)
    ) u_por (
        .clk         (clk),
        .nrst        (nrst),
        .rst_pin_in  (rst_pin_in),
        .rst_pin_out (rst_pin_out),
        .rst_pin_oe  (rst_pin_oe),
        .sys_rst_n   (sys_rst_n)
    );

    assign rst_n       = nrst && sys_rst_n;
    assign accept      = req_valid && ready_ff;
    assign ack_seen    = !ack_s2_ff;
    // internal limit covers the acknowledge synchroniser so the byte ack wins
    assign wait_limit  = boot_ff ? waits_ff + SYNC_LAT
                                 : (sram3_ff ? SRAM_WAITS_3CLK : SRAM_WAITS_2CLK);
    assign term_byte   = boot_ff && (ack_seen || (port8_ff && cnt_ff == wait_limit));
    assign term_word   = (cnt_ff == wait_limit) && !term_byte;
    assign term        = (state_ff == BBC_WAIT) && (term_byte || term_word);
    assign need_second = term_byte && word_ff && !second_ff;
    // read data leaves the input synchroniser two edges after termination
    assign end_ok      = !ack_seen && (cnt_ff >= SYNC_LAT - 3'h1);
    assign wr_next     = accept ? req_write : wr_ff;
    assign byte_in     = din_s2_ff[15:8];
    assign lane_byte   = addr_ff[0] ? din_s2_ff[7:0] : din_s2_ff[15:8];

    // read data assembly: 8-bit port data arrives on the upper lane
    assign nxt_rdata = !cap2_ff     ? rdata_ff :
                       byte_port_ff ? (!word_ff ? {8'h00, byte_in} :
                                       half_ff  ? {byte_in, 8'h00} :
                                                  {rdata_ff[15:8], byte_in}) :
                       word_ff    ? din_s2_ff : {8'h00, lane_byte};

    // write data lanes: byte writes are mirrored so either lane carries them
    assign nxt_dout = second_ff ? {wdata_ff[7:0], wdata_ff[7:0]} :
                      word_ff   ? wdata_ff : {wdata_ff[7:0], wdata_ff[7:0]};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            BBC_IDLE: begin
                if (accept) begin
                    nxt_state = BBC_ADDR;
                end
            end
            BBC_ADDR: begin
                nxt_state = BBC_WAIT;
            end
            BBC_WAIT: begin
                if (term) begin
                    nxt_state = BBC_END;
                end
            end
            BBC_END: begin
                // stale acknowledge must clear before a new cycle starts
                if (end_ok) begin
                    nxt_state = half_ff ? BBC_ADDR : BBC_IDLE;
                end
            end
            default: begin
                nxt_state = BBC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_s1_ff <= 1'b1;
            ack_s2_ff <= 1'b1;
            din_s1_ff <= DATA_RST;
            din_s2_ff <= DATA_RST;
        end else begin
            ack_s1_ff <= byte_port_size_ack_n;
            ack_s2_ff <= ack_s1_ff;
            din_s1_ff <= bus_data_in;
            din_s2_ff <= din_s1_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port8_ff <= BOOT_PORT8_RST;
            waits_ff <= BOOT_WAITS_RST;
            sram3_ff <= SRAM_3CLK_RST;
        end else if (cfg_load) begin
            port8_ff <= cfg_boot_port8;
            waits_ff <= cfg_boot_waits;
            sram3_ff <= cfg_sram_3clk;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= BBC_IDLE;
            ready_ff <= 1'b0;
            done_ff  <= 1'b0;
            half_ff  <= 1'b0;
            cap1_ff  <= 1'b0;
            cap2_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state == BBC_IDLE);
            done_ff  <= (state_ff == BBC_END) && end_ok && !half_ff;
            cap1_ff  <= term;
            cap2_ff  <= cap1_ff;
            if (term && need_second) begin
                half_ff <= 1'b1;
            end else if (state_ff == BBC_END && end_ok) begin
                half_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boot_ff   <= 1'b0;
            wr_ff     <= 1'b0;
            word_ff   <= 1'b0;
            addr_ff   <= ADDR_RST;
            wdata_ff  <= DATA_RST;
            second_ff <= 1'b0;
        end else if (accept) begin
            boot_ff   <= !req_addr[SRAM_SEL_BIT];
            wr_ff     <= req_write;
            word_ff   <= req_word;
            addr_ff   <= req_word ? {req_addr[ADDR_W-1:1], 1'b0} : req_addr;
            wdata_ff  <= req_wdata;
            second_ff <= 1'b0;
        end else if (term && need_second) begin
            second_ff <= 1'b1;
            addr_ff   <= {addr_ff[ADDR_W-1:1], 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff       <= 3'h0;
            cs_boot_n_ff <= 1'b1;
            cs_sram_n_ff <= 1'b1;
            doe_ff       <= 1'b0;
            dout_ff      <= DATA_RST;
            size_byte_ff <= 1'b0;
            rdata_ff     <= DATA_RST;
            byte_port_ff <= 1'b0;
        end else begin
            cnt_ff       <= (state_ff == nxt_state) ? cnt_ff + 3'h1 : 3'h0;
            cs_boot_n_ff <= !(boot_ff && nxt_state == BBC_WAIT);
            cs_sram_n_ff <= !(!boot_ff && nxt_state == BBC_WAIT);
            doe_ff       <= wr_next && (nxt_state == BBC_ADDR || nxt_state == BBC_WAIT);
            dout_ff      <= nxt_dout;
            size_byte_ff <= !word_ff || second_ff;
            rdata_ff     <= wr_ff ? rdata_ff : nxt_rdata;
            byte_port_ff <= term ? term_byte : byte_port_ff;
        end
    end

    assign req_ready          = ready_ff;
    assign resp_done          = done_ff;
    assign resp_rdata         = rdata_ff;
    assign resp_byte_port     = byte_port_ff;
    assign bus_addr           = addr_ff;
    assign bus_read           = !wr_ff;
    assign bus_size_byte      = size_byte_ff;
    assign boot_chip_select_n = cs_boot_n_ff;
    assign sram_chip_select_n = cs_sram_n_ff;
    assign bus_data_out       = dout_ff;
    assign bus_data_oe        = doe_ff;
endmodule

/* src/bbc_pkg.sv */
// boot and sram bus controller constants and types
package bbc_pkg;
    localparam int          ADDR_W          = 24;
    localparam int          DATA_W          = 16;
    localparam logic [2:0]  BOOT_WAITS_RST  = 3'h3;
    localparam logic        BOOT_PORT8_RST  = 1'b0;
    localparam logic        SRAM_3CLK_RST   = 1'b0;
    localparam logic [2:0]  SYNC_LAT        = 3'h2;
    localparam logic [2:0]  SRAM_WAITS_2CLK = 3'h0;
    localparam logic [2:0]  SRAM_WAITS_3CLK = 3'h1;
    localparam int          SRAM_SEL_BIT    = 23;
    localparam int          POR_HOLD_CYCLES = 512;
    localparam int          POR_CNT_W       = 10;
    localparam logic [15:0] DATA_RST        = 16'h0000;
    localparam logic [23:0] ADDR_RST        = 24'h000000;

    typedef enum logic [3:0] {
        BBC_IDLE = 4'h1,
        BBC_ADDR = 4'h2,
        BBC_WAIT = 4'h4,
        BBC_END  = 4'h8
    } bbc_state_e;
endpackage

/* src/bbc_por_reset.sv */
// power-on reset hold and open-drain system reset pin driver
`timescale 1ns/1ps
module bbc_por_reset #(
    parameter int HOLD_CYCLES = bbc_pkg::POR_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // reset pin
    input  wire logic rst_pin_in,
    output logic      rst_pin_out,
    output logic      rst_pin_oe,
    // internal reset
    output logic      sys_rst_n
);
    import bbc_pkg::*;

    logic [POR_CNT_W-1:0] cnt_ff;
    logic                 hold_ff;
    logic                 pin_s1_ff;
    logic                 pin_s2_ff;
    logic                 sys_rst_n_ff;
    logic                 hold_done;
    logic [POR_CNT_W-1:0] nxt_cnt;

    assign hold_done   = (cnt_ff == POR_CNT_W'(HOLD_CYCLES - 1));
    assign nxt_cnt     = hold_done ? cnt_ff : cnt_ff + POR_CNT_W'(1);
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = hold_ff;
    assign sys_rst_n   = sys_rst_n_ff;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_ff       <= '0;
            hold_ff      <= 1'b1;
            pin_s1_ff    <= 1'b0;
            pin_s2_ff    <= 1'b0;
            sys_rst_n_ff <= 1'b0;
        end else begin
            cnt_ff       <= nxt_cnt;
            hold_ff      <= !hold_done;
            pin_s1_ff    <= rst_pin_in;
            pin_s2_ff    <= pin_s1_ff;
            sys_rst_n_ff <= !hold_ff && pin_s2_ff;
        end
    end
endmodule

/* test/bbc_bus_ctrl_assertions.sv */
// concurrent checks on the bus controller ports
`timescale 1ns/1ps
module bbc_bus_ctrl_assertions #(
    parameter int POR_HOLD = 8
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        resp_done,
    input wire logic        resp_byte_port,
    input wire logic [23:0] bus_addr,
    input wire logic        bus_read,
    input wire logic        bus_data_oe,
    input wire logic        boot_chip_select_n,
    input wire logic        sram_chip_select_n,
    input wire logic        byte_port_size_ack_n,
    input wire logic        rst_pin_out,
    input wire logic        rst_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_cs_excl; !(!boot_chip_select_n && !sram_chip_select_n); endproperty
    a_cs_excl: assert property (p_cs_excl) else $error("both selects low");
    property p_boot_len; $fell(boot_chip_select_n) |-> ##[1:6] boot_chip_select_n; endproperty
    a_boot_len: assert property (p_boot_len) else $error("boot select too long");
    property p_ack_end;
        !boot_chip_select_n && !byte_port_size_ack_n |-> ##[1:4] boot_chip_select_n;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("byte ack ignored");
    property p_sram_len; $fell(sram_chip_select_n) |-> ##[1:2] sram_chip_select_n; endproperty
    a_sram_len: assert property (p_sram_len) else $error("sram select too long");
    property p_por; $rose(nrst) |-> rst_pin_oe [*8]; endproperty
    a_por: assert property (p_por) else $error("reset pin released early");
    property p_rst_low; rst_pin_oe |-> !rst_pin_out; endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset pin driven high");
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    a_take: assert property (p_take) else $error("ready after take");
    property p_done; resp_done |-> req_ready ##1 !resp_done; endproperty
    a_done: assert property (p_done) else $error("done not a pulse");
    property p_addr;
        !boot_chip_select_n && !$past(boot_chip_select_n) |-> $stable(bus_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_oe; bus_data_oe |-> !bus_read; endproperty
    a_oe: assert property (p_oe) else $error("drive during read");
    c_byte: cover property ($rose(resp_byte_port));
    c_sram: cover property ($fell(sram_chip_select_n) ##1 sram_chip_select_n);
    c_por: cover property ($fell(rst_pin_oe));
endmodule

bind bbc_bus_ctrl bbc_bus_ctrl_assertions #(.POR_HOLD(POR_HOLD)) u_chk (.clk, .nrst,
    .req_valid, .req_ready, .resp_done, .resp_byte_port, .bus_addr, .bus_read,
    .bus_data_oe, .boot_chip_select_n, .sram_chip_select_n, .byte_port_size_ack_n,
    .rst_pin_out, .rst_pin_oe);

/* test/bbc_mem_model.sv */
// boot rom with falling-edge byte ack counter, plus sram
`timescale 1ns/1ps
module bbc_mem_model (
    input  wire logic        clk,
    input  wire logic        rom8,
    input  wire logic [23:0] bus_addr,
    input  wire logic        bus_size_byte,
    input  wire logic        boot_chip_select_n,
    input  wire logic        sram_chip_select_n,
    input  wire logic [15:0] bus_data_out,
    input  wire logic        bus_data_oe,
    output logic             byte_port_size_ack_n,
    output logic [15:0]      bus_data_in
);
    logic [1:0]  cnt = 2'h0;
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic        sel_d = 1'b0;
    wire         sel = !boot_chip_select_n || !sram_chip_select_n;
    wire  [7:0]  rb = bus_addr[7:0] ^ 8'h5a;
    wire  [15:0] rv = rom8 ? {rb, ~rb} : {rb & 8'hfe ^ 8'h00, rb | 8'h01};
    initial foreach (mem[i]) mem[i] = 16'h0000;
    always @(negedge clk or posedge boot_chip_select_n) begin
        if (boot_chip_select_n) cnt <= 2'h0;
        else if (rom8 && !cnt[1]) cnt <= cnt + 2'h1;
    end
    assign byte_port_size_ack_n = ~cnt[1];
    assign bus_data_in = (sel || sel_d) ? (bus_addr[23] ? mem[bus_addr[4:1]] : rv) : ~last;
    always @(posedge clk) begin
        sel_d <= sel;
        last <= bus_data_in;
        if (!sram_chip_select_n && bus_data_oe) begin
            if (!bus_size_byte || !bus_addr[0]) mem[bus_addr[4:1]][15:8] <= bus_data_out[15:8];
            if (!bus_size_byte || bus_addr[0]) mem[bus_addr[4:1]][7:0] <= bus_data_out[7:0];
        end
    end
endmodule

/* test/tb.sv */
// self-checking bench for the boot and sram bus controller
`timescale 1ns/1ps
module tb;
    import bbc_pkg::*;
    localparam int POR = 8;
    logic        clk, nrst, req_valid, req_write, req_word, cfg_load, cfg_sram_3clk, rom8;
    logic [23:0] req_addr, bus_addr, a;
    logic [15:0] req_wdata, resp_rdata, bus_data_in, bus_data_out, d;
    logic [15:0] sh [16];
    logic        req_ready, resp_done, resp_byte_port, bus_read, bus_size_byte, wd;
    logic        boot_chip_select_n, sram_chip_select_n, byte_port_size_ack_n;
    logic        bus_data_oe, rst_pin_out, rst_pin_oe;
    logic        cfg_port8;
    logic [2:0]  cfg_waits;
    int          err_count, comparisons, cyc, n, i;
    integer      seed;
    wire         rst_pin_in = rst_pin_oe ? rst_pin_out : 1'b1;
    bbc_bus_ctrl #(.POR_HOLD(POR)) u_dut (.clk, .nrst, .req_valid, .req_write, .req_word,
        .req_addr, .req_wdata, .req_ready, .resp_done, .resp_rdata, .resp_byte_port,
        .cfg_load, .cfg_boot_port8(cfg_port8), .cfg_boot_waits(cfg_waits), .cfg_sram_3clk,
        .bus_addr, .bus_read, .bus_size_byte, .boot_chip_select_n, .sram_chip_select_n,
        .byte_port_size_ack_n, .bus_data_in, .bus_data_out, .bus_data_oe, .rst_pin_in,
        .rst_pin_out, .rst_pin_oe);
    bbc_mem_model u_mem (.clk, .rom8, .bus_addr, .bus_size_byte, .boot_chip_select_n,
        .sram_chip_select_n, .bus_data_out, .bus_data_oe, .byte_port_size_ack_n, .bus_data_in);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [7:0] rom_b(input logic [23:0] x);
        return x[7:0] ^ 8'h5a;
    endfunction
    task automatic stop_test;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic w, input logic [23:0] ad,
                        input logic [15:0] dd, output int c);
        int k;
        k = 0;
        req_valid <= 1'b1;
        req_write <= wr;
        req_word <= w;
        req_addr <= ad;
        req_wdata <= dd;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 200);
        req_valid <= 1'b0;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (resp_done !== 1'b1 && c < 200);
        if (k >= 200 || c >= 200) begin
            err_count++;
            stop_test;
        end
    endtask
    initial begin
        seed = 32'h5502;
        err_count = 0;
        comparisons = 0;
        {nrst, req_valid, req_write, req_word, cfg_load, cfg_sram_3clk, rom8} = 7'h00;
        req_addr = 24'h000000;
        req_wdata = 16'h0000;
        cfg_port8 = 1'b0;
        cfg_waits = BOOT_WAITS_RST;
        foreach (sh[j]) sh[j] = 16'h0000;
        repeat (3) @(posedge clk);
        chk(rst_pin_oe, 1'b1);
        nrst <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rst_pin_oe !== 1'b0 && n < 100);
        chk(n >= POR && n <= POR + 4, 1'b1);
        a = {1'b0, 22'($random(seed)), 1'b0};
        xfer(1'b0, 1'b1, a, 16'h0000, cyc);
        chk(cyc, 10);
        chk(resp_rdata, {rom_b(a) & 8'hfe, rom_b(a) | 8'h01});
        chk(resp_byte_port, 1'b0);
        rom8 <= 1'b1;
        for (i = 0; i < 4; i++) begin
            a = {1'b0, 23'($random(seed))};
            xfer(1'b0, i[0], a, 16'h0000, cyc);
            a[0] = a[0] & !i[0];
            chk(resp_rdata, i[0] ? {rom_b(a), rom_b(a | 24'h1)} : {8'h00, rom_b(a)});
            chk(resp_byte_port, 1'b1);
        end
        for (i = 0; i < 10; i++) begin
            a = {1'b1, 18'h0, 5'($random(seed))};
            d = 16'($random(seed));
            wd = (i == 0) ? 1'b1 : (i < 3) ? 1'b0 : 1'($random(seed));
            xfer(1'b1, wd, a, d, cyc);
            if (wd) sh[a[4:1]] = d;
            else if (a[0]) sh[a[4:1]][7:0] = d[7:0];
            else sh[a[4:1]][15:8] = d[7:0];
            xfer(1'b0, 1'b1, a, 16'h0000, cyc);
            chk(resp_rdata, sh[a[4:1]]);
            chk(cyc, 5);
        end
        cfg_sram_3clk <= 1'b1;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        xfer(1'b0, 1'b1, a, 16'h0000, cyc);
        chk(cyc, 6);
        chk(resp_rdata, sh[a[4:1]]);
        rom8 <= 1'b0;
        cfg_port8 <= 1'b1;
        cfg_waits <= 3'($random(seed)) & 3'h3;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        a = {1'b0, 22'($random(seed)), 1'b0};
        xfer(1'b0, 1'b1, a, 16'h0000, cyc);
        chk(cyc, 24'(2 * (cfg_waits + SYNC_LAT) + 9));
        chk(resp_rdata, {rom_b(a) & 8'hfe, rom_b(a | 24'h1) & 8'hfe});
        chk(resp_byte_port, 1'b1);
        stop_test;
    end
endmodule
